// ### timer_irq_adc_trigger.sv
// Status flags, request outputs and conversion triggers for a six-channel timer.
//
// What this block does
// - Three source types, each own flag and enable.
// - Event sets flag; request needs enable bit.
// - Request drops when its flag clears or its enable bit clears.
// - Fixed priority, channel 0 A first, W last.
// - Twenty-one match sources across six channels.
// - Channel 0 E and F ignore captures.
// - One overflow flag per channel 0-4.
// - Underflow flags only on channels 1, 2.
// - Register A flag pulses shared conversion line.
// - Channel 4 trough pulses shared line too.
// - Channel 0 E match pulses own line.
// - Delay compare matches pulse delayed lines.
// - Flag clears after read-one then write-zero.
`timescale 1ns/10ps

module timer_irq_adc_trigger (
    input  wire logic                                clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                cyc_i,
    input  wire logic                                stb_i,
    input  wire logic                                we_i,
    input  wire logic [7:0]                          adr_i,
    input  wire logic [3:0]                          sel_i,
    input  wire logic [31:0]                         dat_i,
    output logic      [31:0]                         dat_o,
    output logic                                     ack_o,
    input  wire timer_irq_pkg::src_event_s           src_i,
    input  wire timer_irq_pkg::ch4_count_s           ch4_i,
    output logic      [timer_irq_pkg::NSRC-1:0]      irq_req_o,
    output logic                                     irq_o,
    output logic                                     shared_conv_request_o,
    output logic                                     ch0_e_conv_request_o,
    output logic                                     delayed_conv_request_a_o,
    output logic                                     delayed_conv_request_b_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [timer_irq_pkg::NSRC-1:0]  event_flag_register;
    logic [timer_irq_pkg::NSRC-1:0]  request_enable_register;
    logic [timer_irq_pkg::NSRC-1:0]  armed;
    logic [timer_irq_pkg::TRG_W-1:0] trig_ctrl;
    logic [timer_irq_pkg::CW-1:0]    delay_compare_a;
    logic [timer_irq_pkg::CW-1:0]    delay_compare_b;
    logic [timer_irq_pkg::NCONV-1:0] conv_status;
    logic [timer_irq_pkg::NCONV-1:0] conv_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Expands byte enables into a bit mask; used by every writable register.
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Requests are answered one cycle after they appear; writes commit at the
    // edge where the master sees ack, so a held request never writes twice.
    wire        req      = cyc_i & stb_i;
    wire        take     = req & ~ack_o;
    wire        commit   = req & ack_o & we_i;
    wire        rd_take  = take & ~we_i;
    wire [31:0] wmask    = lane_mask(sel_i);
    wire        hit_flag = adr_i == timer_irq_pkg::FLAG_OFS;
    wire        hit_ena  = adr_i == timer_irq_pkg::ENA_OFS;
    wire        hit_trg  = adr_i == timer_irq_pkg::TRG_OFS;
    wire        hit_dcmp = adr_i == timer_irq_pkg::DCMP_OFS;
    wire        hit_cst  = adr_i == timer_irq_pkg::CST_OFS;
    wire        hit_cmsk = adr_i == timer_irq_pkg::CMSK_OFS;
    wire [31:0] wr_merge_ena = (32'(request_enable_register) & ~wmask) | (dat_i & wmask);
    wire [31:0] wr_merge_trg = (32'(trig_ctrl) & ~wmask) | (dat_i & wmask);
    wire [31:0] wr_merge_dcm = ({delay_compare_b, delay_compare_a} & ~wmask)
                             | (dat_i & wmask);
    wire [31:0] wr_merge_cmk = (32'(conv_mask) & ~wmask) | (dat_i & wmask);

    // Read multiplexer; unmapped offsets answer with zero.
    wire [31:0] rd_data =
        hit_flag ? 32'(event_flag_register) :
        hit_ena  ? 32'(request_enable_register) :
        hit_trg  ? 32'(trig_ctrl) :
        hit_dcmp ? {delay_compare_b, delay_compare_a} :
        hit_cst  ? 32'(conv_status) :
        hit_cmsk ? 32'(conv_mask) : timer_irq_pkg::ZERO32;

    ////////////////////////////////////////////////////////////////////////////
    // Flag set and clear.

    // A capture on the compare-only sources is dropped before it can set a
    // flag, so software never sees those flags from capture hardware.
    wire [timer_irq_pkg::NSRC-1:0] set_flag =
        src_i.hit & ~(src_i.capture & timer_irq_pkg::CMP_ONLY);

    // Only bits that were read as one and are now written as zero clear.
    wire [timer_irq_pkg::NSRC-1:0] clr_flag =
        {timer_irq_pkg::NSRC{commit & hit_flag}} & armed
        & ~dat_i[timer_irq_pkg::NSRC-1:0] & wmask[timer_irq_pkg::NSRC-1:0];

    // A new event in the clearing cycle keeps the flag set.
    wire [timer_irq_pkg::NSRC-1:0] next_flag =
        (event_flag_register & ~clr_flag) | set_flag;

    // Arming follows the value returned by a flag read; a clear disarms.
    wire [timer_irq_pkg::NSRC-1:0] next_armed =
        (rd_take & hit_flag) ? event_flag_register : (armed & ~clr_flag);

    wire [timer_irq_pkg::NSRC-1:0] next_ena =
        (commit & hit_ena) ? wr_merge_ena[timer_irq_pkg::NSRC-1:0]
                           : request_enable_register;

    // Each request is a plain AND, so masking never loses the flag. Bit order
    // is the fixed priority order; ranking between channels is left outside.
    wire [timer_irq_pkg::NSRC-1:0] next_req = next_flag & next_ena;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion triggers.

    logic [timer_irq_pkg::NTRG-1:0] a_trig;

    // Register A flags of channels 0 to 4 feed one shared line.
    genvar g;
    generate
        for (g = 0; g < timer_irq_pkg::NTRG; g++) begin : gen_atrig
            assign a_trig[g] = set_flag[timer_irq_pkg::A_IDX[g]] & trig_ctrl[g];
        end
    endgenerate

    wire trough_trig = ch4_i.trough & ch4_i.cpwm
                     & trig_ctrl[timer_irq_pkg::TRG_TROUGH];
    wire next_shared = (|a_trig) | trough_trig;
    wire next_ch0e   = set_flag[timer_irq_pkg::CH0_E]
                     & trig_ctrl[timer_irq_pkg::TRG_CH0E];

    // Direction picks which of the up or down enables applies.
    wire dir_a = ch4_i.up ? trig_ctrl[timer_irq_pkg::TRG_UPA]
                          : trig_ctrl[timer_irq_pkg::TRG_DNA];
    wire dir_b = ch4_i.up ? trig_ctrl[timer_irq_pkg::TRG_UPB]
                          : trig_ctrl[timer_irq_pkg::TRG_DNB];
    wire next_dly_a = ch4_i.tick & (ch4_i.count == delay_compare_a) & dir_a;
    wire next_dly_b = ch4_i.tick & (ch4_i.count == delay_compare_b) & dir_b;

    // Conversion events are sticky for software; write one to clear.
    wire [timer_irq_pkg::NCONV-1:0] conv_set = {next_dly_b, next_dly_a, next_ch0e, next_shared};
    wire [timer_irq_pkg::NCONV-1:0] conv_clr =
        {timer_irq_pkg::NCONV{commit & hit_cst}}
        & dat_i[timer_irq_pkg::NCONV-1:0] & wmask[timer_irq_pkg::NCONV-1:0];
    wire [timer_irq_pkg::NCONV-1:0] next_cst  = (conv_status & ~conv_clr) | conv_set;
    wire [timer_irq_pkg::NCONV-1:0] next_cmsk =
        (commit & hit_cmsk) ? wr_merge_cmk[timer_irq_pkg::NCONV-1:0] : conv_mask;
    wire next_irq = (|next_req) | (|(next_cst & next_cmsk));

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Bus answer: one-cycle ack, read data latched with it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= timer_irq_pkg::ZERO32;
        end else begin
            ack_o <= take;
            dat_o <= rd_take ? rd_data : timer_irq_pkg::ZERO32;
        end
    end

    // Flags, enables and request outputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_flag_register     <= '0;
            request_enable_register <= '0;
            armed                   <= '0;
            irq_req_o               <= '0;
            irq_o                   <= 1'b0;
        end else begin
            event_flag_register     <= next_flag;
            request_enable_register <= next_ena;
            armed                   <= next_armed;
            irq_req_o               <= next_req;
            irq_o                   <= next_irq;
        end
    end

    // Trigger control and delay compare values.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_ctrl       <= '0;
            delay_compare_a <= '0;
            delay_compare_b <= '0;
        end else begin
            if (commit & hit_trg) begin
                trig_ctrl <= wr_merge_trg[timer_irq_pkg::TRG_W-1:0];
            end
            if (commit & hit_dcmp) begin
                delay_compare_a <= wr_merge_dcm[timer_irq_pkg::CW-1:0];
                delay_compare_b <= wr_merge_dcm[31:timer_irq_pkg::CW];
            end
        end
    end

    // Conversion request pulses and their status bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_status              <= '0;
            conv_mask                <= '0;
            shared_conv_request_o    <= 1'b0;
            ch0_e_conv_request_o     <= 1'b0;
            delayed_conv_request_a_o <= 1'b0;
            delayed_conv_request_b_o <= 1'b0;
        end else begin
            conv_status              <= next_cst;
            conv_mask                <= next_cmsk;
            shared_conv_request_o    <= next_shared;
            ch0_e_conv_request_o     <= next_ch0e;
            delayed_conv_request_a_o <= next_dly_a;
            delayed_conv_request_b_o <= next_dly_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_flag_event_set: assert property (
        src_i.hit[timer_irq_pkg::CH1_A] |=> event_flag_register[timer_irq_pkg::CH1_A])
        else $error("Event did not set its flag.");

    // Masking must hold the request low while the flag itself survives.
    a_req_tracks_and: assert property (
        (event_flag_register[timer_irq_pkg::CH1_A]
         && !request_enable_register[timer_irq_pkg::CH1_A]
         && !clr_flag[timer_irq_pkg::CH1_A] && !(commit && hit_ena))
        |=> !irq_req_o[timer_irq_pkg::CH1_A] && event_flag_register[timer_irq_pkg::CH1_A])
        else $error("Masked request not low or its flag lost.");

    a_capture_ignored: assert property (
        (src_i.hit[timer_irq_pkg::CH0_F] && src_i.capture[timer_irq_pkg::CH0_F]
         && !event_flag_register[timer_irq_pkg::CH0_F])
        |=> !event_flag_register[timer_irq_pkg::CH0_F])
        else $error("Compare-only flag set by a capture.");

    a_clear_needs_read: assert property (
        $fell(event_flag_register[timer_irq_pkg::CH0_A]) |-> $past(armed[timer_irq_pkg::CH0_A]))
        else $error("Flag cleared without a prior read.");

    a_req_held: assert property (
        (irq_req_o[timer_irq_pkg::CH0_A] && request_enable_register[timer_irq_pkg::CH0_A]
         && !clr_flag[timer_irq_pkg::CH0_A] && !(commit && hit_ena))
        |=> irq_req_o[timer_irq_pkg::CH0_A])
        else $error("Request dropped while flag still set.");

    a_shared_pulse: assert property (
        (set_flag[timer_irq_pkg::CH4_A] && trig_ctrl[timer_irq_pkg::NTRG-1])
        |=> shared_conv_request_o)
        else $error("Register A event gave no shared trigger.");

    a_trough_pulse: assert property (
        (ch4_i.trough && ch4_i.cpwm && !trig_ctrl[timer_irq_pkg::TRG_TROUGH] && !(|a_trig))
        |=> !shared_conv_request_o)
        else $error("Trough trigger fired while disabled.");

    a_ch0e_pulse: assert property (
        ch0_e_conv_request_o |-> $past(set_flag[timer_irq_pkg::CH0_E])
        && $past(trig_ctrl[timer_irq_pkg::TRG_CH0E]))
        else $error("Channel 0 E trigger without its cause.");

    a_delay_match: assert property (
        delayed_conv_request_a_o |-> $past(ch4_i.tick) && $past(ch4_i.count == delay_compare_a))
        else $error("Delayed trigger A without a count match.");

    a_ack_single: assert property (
        ack_o |=> !ack_o)
        else $error("Ack held for more than one cycle.");

endmodule

// ### timer_irq_pkg.sv
// Shared constants and carrier types for the timer request and conversion trigger block.
package timer_irq_pkg;

    // Source count and the channels that can raise a conversion trigger.
    localparam int NSRC = 28;
    localparam int NTRG = 5;
    localparam int NCONV = 4;

    // Flag positions in priority order, highest first.
    localparam int CH0_A = 0;
    localparam int CH0_E = 5;
    localparam int CH0_F = 6;
    localparam int CH1_A = 7;
    localparam int CH2_A = 11;
    localparam int CH3_A = 15;
    localparam int CH4_A = 20;
    localparam int A_IDX [NTRG] = '{CH0_A, CH1_A, CH2_A, CH3_A, CH4_A};

    // Sources that only react to a compare match, never to a capture.
    localparam logic [NSRC-1:0] CMP_ONLY = 28'h0000060;

    // Register byte offsets on the bus.
    localparam logic [7:0] FLAG_OFS = 8'h00;
    localparam logic [7:0] ENA_OFS  = 8'h04;
    localparam logic [7:0] TRG_OFS  = 8'h08;
    localparam logic [7:0] DCMP_OFS = 8'h0c;
    localparam logic [7:0] CST_OFS  = 8'h10;
    localparam logic [7:0] CMSK_OFS = 8'h14;

    // Trigger control fields.
    localparam int TRG_TROUGH = 5;
    localparam int TRG_CH0E   = 6;
    localparam int TRG_UPA    = 7;
    localparam int TRG_DNA    = 8;
    localparam int TRG_UPB    = 9;
    localparam int TRG_DNB    = 10;
    localparam int TRG_W      = 11;

    // Conversion event status bits.
    localparam int CV_SHARED = 0;
    localparam int CV_CH0E   = 1;
    localparam int CV_DLYA   = 2;
    localparam int CV_DLYB   = 3;

    // Counter width and reset values.
    localparam int CW = 16;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    // Event pulses from the counter channels, one bit per source.
    typedef struct packed {
        logic [NSRC-1:0] hit;
        logic [NSRC-1:0] capture;
    } src_event_s;

    // Channel 4 counter view used by the trough and delayed triggers.
    typedef struct packed {
        logic          tick;
        logic          up;
        logic          cpwm;
        logic          trough;
        logic [CW-1:0] count;
    } ch4_count_s;

endpackage

// ### adc_model.sv
// Behavioural conversion-start sink standing at the far side of the trigger lines.
`timescale 1ns/10ps

module adc_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] pick_i,
    input  wire logic [3:0] req_i,
    output logic      [7:0] starts_o
);
    // Only the selected request line starts a conversion, so stray pulses elsewhere are harmless.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            starts_o <= 8'h00;
        end else if (req_i[pick_i]) begin
            starts_o <= starts_o + 8'h01;
        end
    end
endmodule

// ### tb_top.sv
// Self-checking bench for the timer request and conversion trigger block.
`timescale 1ns/10ps

module tb_top;
    logic                             clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic [7:0]                       adr_i;
    logic [3:0]                       sel_i, wsel;
    logic [31:0]                      dat_i, dat_o, q;
    logic [27:0]                      irq_req_o, all_f;
    wire  [3:0]                       conv;
    logic [3:0]                       cv;
    logic [7:0]                       starts;
    logic [1:0]                       pick;
    timer_irq_pkg::src_event_s        src_i;
    timer_irq_pkg::ch4_count_s        ch4_i;
    int                               miscompares = 0;
    int                               n_compared = 0;

    // The sink watches all four lines but counts only the shared one.
    timer_irq_adc_trigger dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .src_i(src_i), .ch4_i(ch4_i), .irq_req_o(irq_req_o), .irq_o(irq_o),
        .shared_conv_request_o(conv[0]), .ch0_e_conv_request_o(conv[1]),
        .delayed_conv_request_a_o(conv[2]), .delayed_conv_request_b_o(conv[3]));
    adc_model sink_u (.clk_i(clk_i), .rst_i(rst_i), .pick_i(pick), .req_i(conv),
        .starts_o(starts));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 250 MHz.
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // One comparison, reported at once on a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic bus cycle; the request is held until ack is seen at a rising edge.
    // No wait limit here: a slave that never answers is caught by the watchdog.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= wsel;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Registered outputs follow at the commit edge itself; this waits two edges more.
    task automatic settle;
        repeat (2) @(posedge clk_i);
    endtask

    // One-cycle event pulse; the trigger lines are caught in the cycle after it.
    task automatic ev(input logic [27:0] h, input logic [27:0] c, input logic [19:0] k);
        src_i <= {h, c};
        ch4_i <= k;
        @(posedge clk_i);
        src_i <= '0;
        ch4_i <= '0;
        @(posedge clk_i);
        cv = conv;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end

    // Main sequence: flags, masking, clearing, then every trigger path.
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        src_i = '0;
        ch4_i = '0;
        pick = 2'd0;
        all_f = 28'hfffffff;
        wsel = 4'hf;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(timer_irq_pkg::FLAG_OFS, 32'h0);
        rd(timer_irq_pkg::ENA_OFS, 32'h0);
        wb(1'b1, 8'h20, 32'hffffffff);
        rd(8'h20, 32'h0);
        wb(1'b1, timer_irq_pkg::ENA_OFS, {4'h0, all_f});
        rd(timer_irq_pkg::ENA_OFS, {4'h0, all_f});
        ev(28'h61, 28'h61, 20'h0);
        chk({4'h0, irq_req_o}, 32'h1);
        for (int i = 1; i < 28; i++) begin
            ev(28'h1 << i, 28'h0, 20'h0);
            chk({4'h0, irq_req_o}, 32'hffffffff >> (31 - i));
        end
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, timer_irq_pkg::ENA_OFS, 32'h0);
        settle();
        chk({4'h0, irq_req_o}, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, timer_irq_pkg::FLAG_OFS, 32'h0);
        wb(1'b1, timer_irq_pkg::ENA_OFS, {4'h0, all_f});
        settle();
        chk({4'h0, irq_req_o}, {4'h0, all_f});
        rd(timer_irq_pkg::FLAG_OFS, {4'h0, all_f});
        wb(1'b1, timer_irq_pkg::FLAG_OFS, 32'h0ffffffe);
        settle();
        chk({4'h0, irq_req_o}, 32'h0ffffffe);
        wb(1'b1, timer_irq_pkg::FLAG_OFS, 32'h0);
        settle();
        chk({4'h0, irq_req_o}, 32'h0);
        // Each register-A trigger enable reaches the shared line only for its own channel.
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, timer_irq_pkg::TRG_OFS, 32'h1 << c);
            ev(28'h1 << timer_irq_pkg::A_IDX[c], 28'h0, 20'h0);
            chk({28'h0, cv}, 32'h1);
            ev(28'h1 << timer_irq_pkg::A_IDX[(c + 1) % 5], 28'h0, 20'h0);
            chk({28'h0, cv}, 32'h0);
        end
        wb(1'b1, timer_irq_pkg::TRG_OFS, 32'h1 << timer_irq_pkg::TRG_CH0E);
        ev(28'h1 << timer_irq_pkg::CH0_E, 28'h0, 20'h0);
        chk({28'h0, cv}, 32'h2);
        wb(1'b1, timer_irq_pkg::TRG_OFS, 32'h1 << timer_irq_pkg::TRG_TROUGH);
        ev(28'h0, 28'h0, {4'b0011, 16'h0000});
        chk({28'h0, cv}, 32'h1);
        ev(28'h0, 28'h0, {4'b0001, 16'h0000});
        chk({28'h0, cv}, 32'h0);
        wb(1'b1, timer_irq_pkg::DCMP_OFS, 32'h0020_0010);
        wb(1'b1, timer_irq_pkg::TRG_OFS, 32'h0000_0480);
        ev(28'h0, 28'h0, {4'b1100, 16'h0010});
        chk({28'h0, cv}, 32'h4);
        ev(28'h0, 28'h0, {4'b1000, 16'h0010});
        chk({28'h0, cv}, 32'h0);
        ev(28'h0, 28'h0, {4'b1000, 16'h0020});
        chk({28'h0, cv}, 32'h8);
        // The other two direction enables, then a trough with its enable off.
        wb(1'b1, timer_irq_pkg::TRG_OFS, 32'h0000_0300);
        ev(28'h0, 28'h0, {4'b1100, 16'h0020});
        chk({28'h0, cv}, 32'h8);
        ev(28'h0, 28'h0, {4'b1000, 16'h0010});
        chk({28'h0, cv}, 32'h4);
        ev(28'h0, 28'h0, {4'b0011, 16'h0000});
        chk({28'h0, cv}, 32'h0);
        // A single byte lane must leave the other three bytes untouched.
        wsel = 4'h1;
        wb(1'b1, timer_irq_pkg::DCMP_OFS, 32'hffff_ffff);
        wsel = 4'hf;
        rd(timer_irq_pkg::DCMP_OFS, 32'h0020_00ff);
        chk({24'h0, starts}, 32'h6);
        // Conversion events also raise the interrupt line, but only where unmasked.
        wb(1'b1, timer_irq_pkg::ENA_OFS, 32'h0);
        rd(timer_irq_pkg::CST_OFS, 32'hf);
        settle();
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, timer_irq_pkg::CMSK_OFS, 32'h1);
        settle();
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, timer_irq_pkg::CST_OFS, 32'h1);
        rd(timer_irq_pkg::CST_OFS, 32'he);
        chk({31'h0, irq_o}, 32'h0);
        wrap_up();
    end
endmodule
